// ===== rtl/scr_pkg.sv
// Purpose: shared constants and types of the link control/error register bank
// Assumes: 100 MHz system clock, one clock domain
// Notes: used by the device end, the host end, the link monitor and the bench
package scr_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int SCR_CLK_NS = 10;
	localparam int SCR_WORD_NS = 40;
	localparam int SCR_TIMEOUT_WORDS = 4;
	localparam int SCR_TIMEOUT_NS = SCR_TIMEOUT_WORDS * SCR_WORD_NS;
	localparam int SCR_TIMEOUT_CYC = (SCR_TIMEOUT_NS + SCR_CLK_NS - 1) / SCR_CLK_NS;
	localparam int SCR_TMR_W = 8;
	// ****************************************************************
	// link register select codes
	// ****************************************************************
	localparam logic [1:0] SCR_SEL_DATA = 2'h0;
	localparam logic [1:0] SCR_SEL_CTRL = 2'h1;
	localparam logic [1:0] SCR_SEL_ERR = 2'h2;
	// ****************************************************************
	// link_control layout
	// ****************************************************************
	localparam int SCR_CTRL_CLEAR_N = 0;
	localparam int SCR_CTRL_WIDTH32 = 1;
	localparam int SCR_CTRL_TEST_LO = 2;
	localparam int SCR_CTRL_TEST_HI = 3;
	localparam int SCR_CTRL_IGN_TO_N = 4;
	localparam logic [31:0] SCR_CTRL_RESET = 32'hffffffff;
	localparam logic [31:0] SCR_CTRL_FORCE_ONES = 32'hffffffec;
	// ****************************************************************
	// link_error_flags layout
	// ****************************************************************
	localparam int SCR_ERR_OVERWRITE = 0;
	localparam int SCR_ERR_WORD_MISS = 1;
	localparam int SCR_ERR_SYNC_MISS = 2;
	localparam int SCR_ERR_W = 3;
	// ****************************************************************
	// host APB register map
	// ****************************************************************
	localparam logic [7:0] SCR_OFS_CMD = 8'h00;
	localparam logic [7:0] SCR_OFS_WDATA = 8'h04;
	localparam logic [7:0] SCR_OFS_RDATA = 8'h08;
	localparam logic [7:0] SCR_OFS_STATUS = 8'h0c;
	localparam logic [7:0] SCR_OFS_IRQ_ST = 8'h10;
	localparam logic [7:0] SCR_OFS_IRQ_MASK = 8'h14;
	localparam int SCR_CMD_READ = 2;
	localparam int SCR_IRQ_DONE = 0;
	localparam int SCR_IRQ_FULL = 1;
	localparam int SCR_IRQ_ERROR = 2;
	localparam int SCR_IRQ_W = 3;
	typedef enum logic [1:0] {
		SCR_IDLE = 2'b00,
		SCR_TX = 2'b01,
		SCR_RX = 2'b10
	} scr_mode_type;
	typedef enum logic [1:0] {
		SCR_H_IDLE = 2'b00,
		SCR_H_STROBE = 2'b01,
		SCR_H_SAMPLE = 2'b10
	} scr_hstate_type;
endpackage : scr_pkg

// ===== rtl/scr_link_if.sv
// Purpose: parallel host bus between host logic and the link device
// Assumes: both ends on CLK_SYS_I
// Notes: the shared data wire is resolved here from the two enables
`timescale 1ns/10ps
interface scr_link_if;
	logic host_access_strobe;
	logic read_not_write;
	logic [1:0] register_select;
	logic [31:0] host_data;
	logic host_data_oe;
	logic [31:0] dev_data;
	logic dev_data_oe;
	logic [31:0] bus_data;
	logic rx_full;
	logic link_error;
	// undriven bus floats high
	assign bus_data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 32'hffffffff);
	modport host (output host_access_strobe, output read_not_write, output register_select,
		output host_data, output host_data_oe, input bus_data, input rx_full,
		input link_error);
	modport dev (input host_access_strobe, input read_not_write, input register_select,
		output dev_data, output dev_data_oe, input bus_data, output rx_full,
		output link_error);
endinterface : scr_link_if

// ===== rtl/scr_device.sv
// Purpose: control and error register bank of the serial link transceiver
// Assumes: serializer/deserializer datapaths report events as one-cycle pulses
// Notes: one access per strobe; read data driven one cycle after the strobe
// Contract
// RQ1: clear low resets logic, aborts activity
// RQ2: clear written high returns to idle
// RQ3: width bit selects 32 or 16 bits
// RQ4: host keeps factory test bits high
// RQ5: ignore-timeout low disregards transmit expiry
// RQ6: host rewrites bit high to end; code ends transmit only at a later expiry, after a word start if timer is 0
// RQ7: overwrite flag on unread data replaced
// RQ8: no overwrite flag while idle
// RQ9: word-missing flag only at timeout expiry
// RQ10: sync-missing flag on absent sync bit
// RQ11: host writes reserved bits high
// RQ12: reserved bits read as don't care
// RQ13: timer four word periods, restarts per word
// RQ14: receive-full raised on received word
// RQ15: reset default is idle, bus cut off
// RQ16: flags sticky until clear, drive error
// RQ17: single fixed field map in package
`timescale 1ns/10ps
module scr_device #(
	parameter int TIMEOUT_CYC = scr_pkg::SCR_TIMEOUT_CYC
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	scr_link_if.dev LINK,
	input wire logic RX_ACTIVITY_I,
	input wire logic RX_HALF_I,
	input wire logic RX_WORD_I,
	input wire logic [31:0] RX_DATA_I,
	input wire logic SYNC_MISSING_I,
	input wire logic TX_WORD_START_I,
	output logic [1:0] MODE_O,
	output logic SERIAL_ENABLE_O,
	output logic TX_LOAD_O,
	output logic [31:0] TX_DATA_O,
	output logic WIDTH32_O,
	output logic LOGIC_CLEAR_N_O
);
	import scr_pkg::*;
	typedef struct packed {
		scr_mode_type mode;
		logic [31:0] ctrl;
		logic [SCR_ERR_W-1:0] flags;
		logic full;
		logic half_pend;
		logic [SCR_TMR_W-1:0] timer;
		logic [31:0] rx_data;
		logic [31:0] tx_data;
		logic tx_load;
		logic [31:0] dout;
		logic doe;
		logic err;
		logic sen;
	} scr_dev_state_type;
	scr_dev_state_type q, d;
	logic expiry;
	logic wide;
	logic acc_wr;
	logic acc_rd;
	function automatic logic [31:0] scr_fit(input logic w32, input logic [31:0] v);
		scr_fit = w32 ? v : {16'h0000, v[15:0]};
	endfunction : scr_fit
	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.tx_load = 1'b0;
		d.doe = 1'b0;
		wide = q.ctrl[SCR_CTRL_WIDTH32];
		acc_wr = LINK.host_access_strobe && !LINK.read_not_write;
		acc_rd = LINK.host_access_strobe && LINK.read_not_write;
		// ****************************************************************
		// timeout timer
		// ****************************************************************
		expiry = (q.timer == SCR_TMR_W'(1));
		if (q.timer != '0) begin
			d.timer = q.timer - SCR_TMR_W'(1);
		end
		// ****************************************************************
		// host register access
		// ****************************************************************
		if (acc_wr) begin
			case (LINK.register_select)
				SCR_SEL_CTRL: begin
					d.ctrl = LINK.bus_data;
				end
				SCR_SEL_DATA: begin
					if (q.mode != SCR_RX) begin
						d.tx_data = scr_fit(wide, LINK.bus_data); // RQ3
						d.tx_load = 1'b1;
						d.mode = SCR_TX;
						d.timer = SCR_TMR_W'(TIMEOUT_CYC); // RQ13
					end
				end
				default: begin
				end
			endcase
		end else if (acc_rd) begin
			d.doe = 1'b1;
			case (LINK.register_select)
				SCR_SEL_DATA: begin
					d.dout = scr_fit(wide, q.rx_data); // RQ3
					// a word landing in this cycle sets full again below
					d.full = 1'b0;
				end
				SCR_SEL_CTRL: begin
					d.dout = q.ctrl; // RQ12
				end
				SCR_SEL_ERR: begin
					d.dout = {{(32 - SCR_ERR_W){1'b0}}, q.flags};
				end
				default: begin
					d.dout = 32'h00000000;
				end
			endcase
		end
		// ****************************************************************
		// link activity
		// ****************************************************************
		case (q.mode)
			SCR_IDLE: begin
				// any line activity opens a reception
				if (RX_ACTIVITY_I) begin
					d.mode = SCR_RX;
					d.timer = SCR_TMR_W'(TIMEOUT_CYC); // RQ13
				end
			end
			SCR_TX: begin
				// a word start in the expiry cycle keeps the link up
				if (TX_WORD_START_I) begin
					d.timer = SCR_TMR_W'(TIMEOUT_CYC); // RQ13
				end else if (expiry && q.ctrl[SCR_CTRL_IGN_TO_N]) begin
					d.mode = SCR_IDLE; // RQ5
				end
			end
			SCR_RX: begin
				if (RX_HALF_I && wide) begin
					d.half_pend = 1'b1;
					d.timer = SCR_TMR_W'(TIMEOUT_CYC); // RQ13
				end
				if (RX_WORD_I) begin
					d.rx_data = RX_DATA_I;
					d.full = 1'b1; // RQ14
					d.half_pend = 1'b0;
					d.timer = SCR_TMR_W'(TIMEOUT_CYC); // RQ13
					if (q.full) begin
						d.flags[SCR_ERR_OVERWRITE] = 1'b1; // RQ7 RQ8
					end
				end
				if (SYNC_MISSING_I) begin
					d.flags[SCR_ERR_SYNC_MISS] = 1'b1; // RQ10
				end
				// a word or any half arriving on expiry blocks the return to idle; a word, or a half in 32-bit mode, restarts the timer
				if (expiry && !RX_WORD_I && !RX_HALF_I) begin
					d.mode = SCR_IDLE; // RQ13
					d.half_pend = 1'b0;
					if (q.half_pend) begin
						d.flags[SCR_ERR_WORD_MISS] = 1'b1; // RQ9
					end
				end
			end
			default: begin
				d.mode = SCR_IDLE;
			end
		endcase
		// ****************************************************************
		// clear condition
		// ****************************************************************
		// holds mode, flags, full, timer and load cleared; reads and tx_data writes still pass
		if (!q.ctrl[SCR_CTRL_CLEAR_N]) begin
			d.mode = SCR_IDLE; // RQ1 RQ2
			d.flags = '0; // RQ16
			d.full = 1'b0;
			d.half_pend = 1'b0;
			d.timer = '0;
			d.tx_load = 1'b0;
		end
		d.err = |d.flags; // RQ16
		d.sen = (d.mode == SCR_TX); // RQ15
	end
	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q <= '0;
			q.mode <= SCR_IDLE; // RQ15
			q.ctrl <= SCR_CTRL_RESET; // RQ17
		end else begin
			q <= d;
		end
	end
	// ****************************************************************
	// outputs
	// ****************************************************************
	assign LINK.dev_data = q.dout;
	assign LINK.dev_data_oe = q.doe;
	assign LINK.rx_full = q.full;
	assign LINK.link_error = q.err;
	assign MODE_O = q.mode;
	assign SERIAL_ENABLE_O = q.sen; // RQ15
	assign TX_LOAD_O = q.tx_load;
	assign TX_DATA_O = q.tx_data;
	assign WIDTH32_O = q.ctrl[SCR_CTRL_WIDTH32];
	assign LOGIC_CLEAR_N_O = q.ctrl[SCR_CTRL_CLEAR_N];
endmodule : scr_device

// ===== rtl/scr_host.sv
// Purpose: APB-controlled host logic that drives the link register bus
// Assumes: APB master per AMBA APB3, one wait state per transfer
// Notes: one link access at a time; commands during an access are dropped
`timescale 1ns/10ps
module scr_host (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic IRQ_O,
	scr_link_if.host LINK
);
	import scr_pkg::*;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		scr_hstate_type st;
		logic [1:0] sel;
		logic rw;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic strobe;
		logic hoe;
		logic [31:0] hdata;
		logic [SCR_IRQ_W-1:0] irq_st;
		logic [SCR_IRQ_W-1:0] irq_mask;
		logic irq;
		logic full_p;
		logic err_p;
	} scr_host_state_type;
	scr_host_state_type q, d;
	logic wr;
	logic [SCR_IRQ_W-1:0] ev;
	logic [SCR_IRQ_W-1:0] w1c;
	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		ev = '0;
		w1c = '0;
		wr = PSEL_I && PENABLE_I && q.pready && PWRITE_I;
		d.pready = PSEL_I && PENABLE_I && !q.pready;
		if (PSEL_I && PENABLE_I && !q.pready) begin
			case (PADDR_I)
				SCR_OFS_CMD: d.prdata = {29'h0, q.rw, q.sel};
				SCR_OFS_WDATA: d.prdata = q.wdata;
				SCR_OFS_RDATA: d.prdata = q.rdata;
				SCR_OFS_STATUS: d.prdata = {29'h0, LINK.link_error, LINK.rx_full,
					q.st != SCR_H_IDLE};
				SCR_OFS_IRQ_ST: d.prdata = {29'h0, q.irq_st};
				SCR_OFS_IRQ_MASK: d.prdata = {29'h0, q.irq_mask};
				default: d.prdata = 32'h00000000;
			endcase
		end
		// link access sequencer
		case (q.st)
			SCR_H_IDLE: begin
				if (wr && PADDR_I == SCR_OFS_CMD) begin
					d.sel = PWDATA_I[1:0];
					d.rw = PWDATA_I[SCR_CMD_READ];
					d.strobe = 1'b1;
					d.hoe = !PWDATA_I[SCR_CMD_READ];
					d.hdata = q.wdata;
					if (PWDATA_I[1:0] == SCR_SEL_CTRL) begin
						d.hdata = q.wdata | SCR_CTRL_FORCE_ONES; // RQ4 RQ11
					end
					d.st = SCR_H_STROBE;
				end
			end
			SCR_H_STROBE: begin
				d.strobe = 1'b0;
				d.hoe = 1'b0;
				if (q.rw) begin
					d.st = SCR_H_SAMPLE;
				end else begin
					d.st = SCR_H_IDLE;
					ev[SCR_IRQ_DONE] = 1'b1;
				end
			end
			SCR_H_SAMPLE: begin
				d.rdata = LINK.bus_data;
				d.st = SCR_H_IDLE;
				ev[SCR_IRQ_DONE] = 1'b1;
			end
			default: begin
				d.st = SCR_H_IDLE;
			end
		endcase
		if (wr && PADDR_I == SCR_OFS_WDATA) begin
			d.wdata = PWDATA_I;
		end
		if (wr && PADDR_I == SCR_OFS_IRQ_MASK) begin
			d.irq_mask = PWDATA_I[SCR_IRQ_W-1:0];
		end
		if (wr && PADDR_I == SCR_OFS_IRQ_ST) begin
			w1c = PWDATA_I[SCR_IRQ_W-1:0];
		end
		d.full_p = LINK.rx_full;
		d.err_p = LINK.link_error;
		ev[SCR_IRQ_FULL] = LINK.rx_full && !q.full_p;
		ev[SCR_IRQ_ERROR] = LINK.link_error && !q.err_p;
		// a new event wins over a clear in the same cycle
		d.irq_st = (q.irq_st & ~w1c) | ev;
		d.irq = |(d.irq_st & d.irq_mask);
	end
	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q <= '0;
			q.st <= SCR_H_IDLE;
		end else begin
			q <= d;
		end
	end
	assign PRDATA_O = q.prdata;
	assign PREADY_O = q.pready;
	assign PSLVERR_O = 1'b0;
	assign IRQ_O = q.irq;
	assign LINK.host_access_strobe = q.strobe;
	assign LINK.read_not_write = q.rw;
	assign LINK.register_select = q.sel;
	assign LINK.host_data = q.hdata;
	assign LINK.host_data_oe = q.hoe;
endmodule : scr_host

// ===== testbench/scr_link_monitor.sv
// Purpose: checks on the link between host logic and device
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the link signals
`timescale 1ns/10ps
module scr_link_monitor
	import scr_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic host_access_strobe,
	input wire logic read_not_write,
	input wire logic [1:0] register_select,
	input wire logic [31:0] host_data,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic rx_full,
	input wire logic link_error
);
	logic clr_wr;
	logic rd_data;
	logic clr_seen_q;
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_N_I);
	assign clr_wr = host_access_strobe && !read_not_write && register_select == SCR_SEL_CTRL
		&& !host_data[SCR_CTRL_CLEAR_N];
	assign rd_data = host_access_strobe && read_not_write && register_select == SCR_SEL_DATA;
	// remembers a clear since the last rise of the error output
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			clr_seen_q <= 1'b0;
		end else if (clr_wr) begin
			clr_seen_q <= 1'b1;
		end else if ($rose(link_error)) begin
			clr_seen_q <= 1'b0;
		end
	end
	chk_read_answer: assert property (host_access_strobe && read_not_write |=> dev_data_oe)
		else $error("read not answered");
	chk_write_silent: assert property (host_access_strobe && !read_not_write |=> !dev_data_oe)
		else $error("device drove bus on write");
	chk_answer_pulse: assert property (dev_data_oe |=> !dev_data_oe)
		else $error("device drive too long");
	chk_host_drive: assert property (host_data_oe |-> host_access_strobe && !read_not_write)
		else $error("host drove bus outside write");
	chk_read_gap: assert property (host_access_strobe && read_not_write |=> !host_access_strobe [*2])
		else $error("read strobes too close");
	chk_reserved_high: assert property (host_access_strobe && !read_not_write
		&& register_select == SCR_SEL_CTRL
		|-> (host_data & SCR_CTRL_FORCE_ONES) == SCR_CTRL_FORCE_ONES)
		else $error("reserved or test bits written low");
	chk_err_sticky: assert property ($fell(link_error) |-> clr_seen_q)
		else $error("error dropped without clear");
	chk_full_cause: assert property ($fell(rx_full) |-> clr_seen_q || $past(rd_data)
		|| $past(rd_data, 2))
		else $error("receive full dropped without read");
	chk_no_clash: assert property (!(host_data_oe && dev_data_oe))
		else $error("both ends drive the bus");
endmodule : scr_link_monitor

// ===== testbench/test_serdes_control_error_regs.sv
// Purpose: self-checking bench of host logic and device joined by the link
// Assumes: APB master in the bench, device events as one-cycle pulses
// Notes: device timeout set to 40 cycles
`timescale 1ns/10ps
module test_serdes_control_error_regs;
	import scr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, txd, rxd = 32'h0, x, r;
	logic [4:0] ev = 5'h0;
	logic [1:0] mode;
	logic pready, irq, w32, clr_n, sen, tx_load;
	int loads = 0;
	logic [63:0] q[$];
	logic [63:0] e;
	int seed = 21;
	int err_total = 0;
	int checks = 0;
	always #5 clk = ~clk;
	scr_link_if link();
	scr_device #(.TIMEOUT_CYC(40)) u_scr_device (.CLK_SYS_I(clk), .RST_N_I(rst_n), .LINK(link),
		.RX_ACTIVITY_I(ev[0]), .RX_HALF_I(ev[1]), .RX_WORD_I(ev[2]), .RX_DATA_I(rxd),
		.SYNC_MISSING_I(ev[3]), .TX_WORD_START_I(ev[4]), .MODE_O(mode), .SERIAL_ENABLE_O(sen),
		.TX_LOAD_O(tx_load), .TX_DATA_O(txd), .WIDTH32_O(w32), .LOGIC_CLEAR_N_O(clr_n));
	scr_host u_scr_host (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(), .IRQ_O(irq), .LINK(link));
	scr_link_monitor u_scr_link_monitor (.CLK_SYS_I(clk), .RST_N_I(rst_n),
		.host_access_strobe(link.host_access_strobe), .read_not_write(link.read_not_write),
		.register_select(link.register_select), .host_data(link.host_data),
		.host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
		.rx_full(link.rx_full), .link_error(link.link_error));
	task automatic cmp(input logic [31:0] a, input logic [31:0] b);
		checks++;
		if (a !== b) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, a, b);
		end
	endtask : cmp
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rv);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] b, input logic [31:0] m);
		q.push_back({m, b});
		apb(1'b0, a, 32'h0, r);
	endtask : rd
	task lk(input logic [1:0] s, input logic rdn, input logic [31:0] d);
		apb(1'b1, SCR_OFS_WDATA, d, r);
		apb(1'b1, SCR_OFS_CMD, {29'h0, rdn, s}, r);
		repeat (20) begin
			apb(1'b0, SCR_OFS_STATUS, 32'h0, r);
			if (r[0] === 1'b0) break;
		end
	endtask : lk
	task pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk) ev <= 5'h0;
		@(posedge clk);
	endtask : pulse
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	// read results checked in order of issue
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
			e = q.pop_front();
			cmp(prdata & e[63:32], e[31:0]);
		end
	end
	// counts transmit load pulses while they stand
	always @(posedge clk) begin
		if (tx_load === 1'b1) begin
			loads <= loads + 1;
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(SCR_OFS_STATUS, 32'h0, 32'h7);
		cmp(mode, SCR_IDLE);
		cmp(sen, 32'h0);
		lk(SCR_SEL_CTRL, 1'b1, 32'h0);
		rd(SCR_OFS_RDATA, 32'h1f, 32'h1f);
		rd(SCR_OFS_CMD, 32'h5, 32'hffffffff);
		rd(8'h20, 32'h0, 32'hffffffff);
		$display("test reset done");
		x = $random(seed);
		lk(SCR_SEL_CTRL, 1'b0, 32'h1d);
		cmp(w32, 32'h0);
		lk(SCR_SEL_DATA, 1'b0, x);
		cmp(txd, x & 32'hffff);
		cmp(loads, 32'h1);
		cmp(mode, SCR_TX);
		cmp(sen, 32'h1);
		repeat (50) @(posedge clk);
		cmp(mode, SCR_IDLE);
		lk(SCR_SEL_CTRL, 1'b0, 32'h0f);
		lk(SCR_SEL_DATA, 1'b0, x);
		repeat (50) @(posedge clk);
		cmp(mode, SCR_TX);
		cmp(txd, x);
		lk(SCR_SEL_CTRL, 1'b0, 32'h1f);
		pulse(4);
		repeat (50) @(posedge clk);
		cmp(mode, SCR_IDLE);
		$display("test transmit done");
		apb(1'b1, SCR_OFS_IRQ_ST, 32'h7, r);
		apb(1'b1, SCR_OFS_IRQ_MASK, 32'h2, r);
		pulse(0);
		cmp(mode, SCR_RX);
		rxd <= $random(seed);
		pulse(2);
		cmp(link.rx_full, 32'h1);
		@(posedge clk);
		cmp(irq, 32'h1);
		rd(SCR_OFS_IRQ_ST, 32'h2, 32'h2);
		x = $random(seed);
		rxd <= x;
		pulse(2);
		lk(SCR_SEL_ERR, 1'b1, 32'h0);
		rd(SCR_OFS_RDATA, 32'h1, 32'h7);
		cmp(link.link_error, 32'h1);
		lk(SCR_SEL_DATA, 1'b1, 32'h0);
		rd(SCR_OFS_RDATA, x, 32'hffffffff);
		apb(1'b1, SCR_OFS_IRQ_ST, 32'h2, r);
		cmp(irq, 32'h0);
		repeat (50) @(posedge clk);
		pulse(0);
		cmp(mode, SCR_RX);
		pulse(1);
		repeat (50) @(posedge clk);
		lk(SCR_SEL_ERR, 1'b1, 32'h0);
		rd(SCR_OFS_RDATA, 32'h3, 32'h7);
		$display("test receive done");
		lk(SCR_SEL_DATA, 1'b0, x);
		lk(SCR_SEL_CTRL, 1'b0, 32'h1e);
		cmp(clr_n, 32'h0);
		cmp(mode, SCR_IDLE);
		cmp(link.link_error, 32'h0);
		lk(SCR_SEL_CTRL, 1'b0, 32'h1f);
		cmp(clr_n, 32'h1);
		cmp(mode, SCR_IDLE);
		cmp(loads, 32'h3);
		pulse(2);
		pulse(2);
		cmp(link.rx_full, 32'h0);
		pulse(0);
		pulse(3);
		lk(SCR_SEL_ERR, 1'b1, 32'h0);
		rd(SCR_OFS_RDATA, 32'h4, 32'h7);
		$display("test clear done");
		end_of_test;
	end
endmodule : test_serdes_control_error_regs
